// ---- logic/ascn_params.svh ----
// register offsets, field positions, reset values and counts of the scan sequencer
`ifndef ASCN_PARAMS_SVH
`define ASCN_PARAMS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define ASCN_OFF_CTRL    8'h00
`define ASCN_OFF_SELA    8'h04
`define ASCN_OFF_SELB    8'h08
`define ASCN_OFF_SELC    8'h0c
`define ASCN_OFF_TRIG    8'h10
`define ASCN_OFF_STAT    8'h14
`define ASCN_OFF_CMD     8'h18
`define ASCN_OFF_DATA    8'h40
`define ASCN_OFF_LAST    8'hb0
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define ASCN_CTRL_MODE   0
`define ASCN_CTRL_DBL    2
`define ASCN_CTRL_GPRI   3
`define ASCN_CTRL_RSCN   4
`define ASCN_CTRL_RSFROM 5
`define ASCN_CTRL_GRP3   6
`define ASCN_CTRL_ADD    7
`define ASCN_CTRL_ADD4   8
`define ASCN_CTRL_RES    9
`define ASCN_CTRL_RATIO  11
`define ASCN_CTRL_XDUP   13
// ----------------------------------------------------------------
// trigger fields, command bits, slots and reset values
// ----------------------------------------------------------------
`define ASCN_TRIG_SRCA   0
`define ASCN_TRIG_SRCB   3
`define ASCN_TRIG_SRCC   6
`define ASCN_TRIG_DBLCH  9
`define ASCN_SRC_EXT     3'h5
`define ASCN_CMD_A       0
`define ASCN_CMD_B       1
`define ASCN_CMD_C       2
`define ASCN_CMD_STOP    3
`define ASCN_NSLOT       29
`define ASCN_SLOT_DUP    5'h1b
`define ASCN_SLOT_XDUP   5'h1c
`define ASCN_ADD_LAST2   4'h3
`define ASCN_ADD_LAST4   4'hf
`define ASCN_CTRL_RST    16'h0000
`define ASCN_TRIG_RST    14'h0000
`define ASCN_SEL_RST     27'h0000000
`endif

// ---- logic/ascn_pkg.sv ----
// types shared by the scan sequencer and its users
package ascn_pkg;
  // scan modes; the fourth code behaves as single scan
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_CONT   = 2'b01,
    MODE_GROUP  = 2'b10,
    MODE_RSVD   = 2'b11
  } ascn_mode_e;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEEK = 2'b01,
    ST_WAIT = 2'b10
  } ascn_state_e;
  // scan groups
  typedef enum logic [1:0] {
    GRP_A = 2'b00,
    GRP_B = 2'b01,
    GRP_C = 2'b10
  } ascn_grp_e;
  // request to the analog converter core
  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
  } ascn_conv_req_s;
  // answer from the analog converter core
  typedef struct packed {
    logic        done;
    logic [11:0] data;
  } ascn_conv_rsp_s;
endpackage : ascn_pkg

// ---- logic/ascn_pick.sv ----
// lowest selected channel at or above a start index
`timescale 1ns/1ps
module ascn_pick #(
  parameter int W  = 27,
  parameter int IW = 5
) (
  // candidate set and start point
  input  wire logic [W-1:0]  mask,
  input  wire logic [IW-1:0] from,
  // result
  output logic               found,
  output logic [IW-1:0]      idx
);
  // scan downward so the lowest hit is the one left standing
  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (mask[i] && (i >= int'(from))) begin
        found = 1'b1;
        idx   = IW'(i);
      end
    end
  end
endmodule : ascn_pick

// ---- logic/ascn_top.sv ----
// scan and trigger sequencer of a 12-bit converter unit, with apb registers
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "ascn_params.svh"
module ascn_top (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // start trigger sources
  input  wire logic                    multifunction_timer_unit_trig,
  input  wire logic                    pulse_timer_unit_trig,
  input  wire logic                    eight_bit_timer_unit_trig,
  input  wire logic                    event_link_unit_trig,
  input  wire logic                    external_start_trigger_n,
  // analog converter core
  output ascn_pkg::ascn_conv_req_s     conv_req,
  output logic                         conv_abort,
  input  wire ascn_pkg::ascn_conv_rsp_s conv_rsp,
  output logic                         conversion_clock,
  // scan end requests
  output logic                         scan_end_irq,
  output logic                         group_b_scan_end_irq
);
  import ascn_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]    ctrl_reg;              // mode and option bits
  logic [13:0]    trig_reg;              // trigger sources, double channel
  logic [26:0]    sel_a_reg;             // group A / plain scan selection
  logic [26:0]    sel_b_reg;             // group B selection
  logic [26:0]    sel_c_reg;             // group C selection
  logic [15:0]    mem [`ASCN_NSLOT];     // result slots
  logic [31:0]    prdata_reg;
  logic           pready_reg;
  logic           pslverr_reg;
  ascn_state_e    state_reg;
  ascn_grp_e      grp_reg;               // group being scanned
  logic [4:0]     ch_reg;                // channel pointer
  logic [15:0]    acc_reg;               // addition accumulator
  logic [3:0]     add_cnt_reg;           // conversions summed so far
  logic           dbl_second_reg;        // next double scan is the second
  logic           xdup_scan_reg;         // extended double scan running
  logic           susp_valid_reg;        // interrupted scan awaits rescan
  ascn_grp_e      susp_grp_reg;
  logic [4:0]     susp_ch_reg;
  logic           ext_prev_reg;          // last pin level
  logic [2:0]     div_cnt_reg;
  logic           tick_reg;              // conversion clock strobe
  ascn_conv_req_s conv_req_reg;
  logic           conv_abort_reg;
  logic           scan_end_irq_reg;
  logic           gb_irq_reg;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire        setup    = psel & ~penable;
  wire        wr_en    = psel & penable & pwrite & pready_reg;
  wire [7:0]  data_off = paddr - `ASCN_OFF_DATA;
  wire [4:0]  slot     = data_off[6:2];
  wire        aligned  = (paddr[1:0] == 2'h0);
  wire        data_hit = aligned && paddr >= `ASCN_OFF_DATA && paddr <= `ASCN_OFF_LAST;
  wire        reg_hit  = aligned && paddr <= `ASCN_OFF_CMD;
  wire        map_hit  = data_hit | reg_hit;
  wire        wr_ctrl  = wr_en && paddr == `ASCN_OFF_CTRL;
  wire        wr_cmd   = wr_en && paddr == `ASCN_OFF_CMD;
  wire        cmd_a    = wr_cmd & pwdata[`ASCN_CMD_A];
  wire        cmd_b    = wr_cmd & pwdata[`ASCN_CMD_B];
  wire        cmd_c    = wr_cmd & pwdata[`ASCN_CMD_C];
  wire        stop     = wr_cmd & pwdata[`ASCN_CMD_STOP];
  wire        idle     = (state_reg == ST_IDLE);
  wire [31:0] stat_w   = {27'h0, susp_valid_reg, dbl_second_reg, grp_reg, ~idle};
  // read mux; command register reads as zero
  wire [31:0] rd_word  =
    data_hit                   ? {16'h0, mem[slot]} :
    paddr == `ASCN_OFF_CTRL    ? {16'h0, ctrl_reg} :
    paddr == `ASCN_OFF_SELA    ? {5'h0, sel_a_reg} :
    paddr == `ASCN_OFF_SELB    ? {5'h0, sel_b_reg} :
    paddr == `ASCN_OFF_SELC    ? {5'h0, sel_c_reg} :
    paddr == `ASCN_OFF_TRIG    ? {18'h0, trig_reg} :
    paddr == `ASCN_OFF_STAT    ? stat_w : 32'h0;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  wire ascn_mode_e mode  = ascn_mode_e'(ctrl_reg[`ASCN_CTRL_MODE +: 2]);
  wire        grp_mode   = (mode == MODE_GROUP);
  wire        gpri       = ctrl_reg[`ASCN_CTRL_GPRI];
  wire        rscn       = ctrl_reg[`ASCN_CTRL_RSCN];
  wire        rsfrom     = ctrl_reg[`ASCN_CTRL_RSFROM];
  wire        grp3       = ctrl_reg[`ASCN_CTRL_GRP3];
  wire        add_on     = ctrl_reg[`ASCN_CTRL_ADD];
  wire        add4       = ctrl_reg[`ASCN_CTRL_ADD4];
  wire [1:0]  res        = ctrl_reg[`ASCN_CTRL_RES +: 2];
  wire [1:0]  ratio      = ctrl_reg[`ASCN_CTRL_RATIO +: 2];
  wire [2:0]  src_a      = trig_reg[`ASCN_TRIG_SRCA +: 3];
  wire [2:0]  src_b      = trig_reg[`ASCN_TRIG_SRCB +: 3];
  wire [2:0]  src_c      = trig_reg[`ASCN_TRIG_SRCC +: 3];
  wire [4:0]  dbl_ch     = trig_reg[`ASCN_TRIG_DBLCH +: 5];
  // continuous scan never runs double trigger
  wire        dbl_on     = ctrl_reg[`ASCN_CTRL_DBL] && mode != MODE_CONT;

  // ----------------------------------------------------------------
  // triggers
  // ----------------------------------------------------------------
  // pin start is a falling edge on the active-low pin
  wire        ext_fall   = ext_prev_reg & ~external_start_trigger_n;
  // source code 0 is software only, 6 and 7 never fire
  wire [7:0]  ev = {2'h0, ext_fall, event_link_unit_trig, eight_bit_timer_unit_trig,
                    pulse_timer_unit_trig, multifunction_timer_unit_trig, 1'b0};
  wire        go_a       = cmd_a | ev[src_a];
  wire        go_b       = grp_mode & (cmd_b | ev[src_b]);
  wire        go_c       = grp_mode & grp3 & (cmd_c | ev[src_c]);
  wire        start      = idle & ~stop & (go_a | go_b | go_c);
  wire ascn_grp_e start_grp = go_a ? GRP_A : go_b ? GRP_B : GRP_C;
  // only group A may cut in, and only with priority enabled
  wire        prio_hit   = grp_mode & gpri & go_a & ~idle & ~stop & (grp_reg != GRP_A);
  wire        xdup_start = dbl_on & ctrl_reg[`ASCN_CTRL_XDUP] & (start_grp == GRP_A)
                           & (src_a == `ASCN_SRC_EXT) & ext_fall;

  // ----------------------------------------------------------------
  // channel selection
  // ----------------------------------------------------------------
  // bits 24 and 25 pick temperature and reference, 26 the diagnosis
  wire [26:0] grp_sel    = !grp_mode         ? sel_a_reg :
                           grp_reg == GRP_B  ? sel_b_reg :
                           grp_reg == GRP_C  ? sel_c_reg : sel_a_reg;
  wire [26:0] dbl_mask   = 27'h0000001 << dbl_ch;
  wire [26:0] cur_mask   = (dbl_on && grp_reg == GRP_A) ? dbl_mask : grp_sel;
  logic       found;
  logic [4:0] pick_idx;

  // next selected channel at or after the pointer
  ascn_pick #(.W(27), .IW(5)) u_pick (
    .mask  (cur_mask),
    .from  (ch_reg),
    .found (found),
    .idx   (pick_idx)
  );

  // ----------------------------------------------------------------
  // sequencing terms
  // ----------------------------------------------------------------
  wire        busy_ok    = ~stop & ~prio_hit;
  wire        seek_go    = (state_reg == ST_SEEK) & tick_reg & busy_ok;
  wire        issue      = seek_go & found;
  wire        scan_done  = seek_go & ~found;
  wire        conv_ok    = (state_reg == ST_WAIT) & conv_rsp.done & busy_ok;
  wire [3:0]  add_last   = !add_on ? 4'h0 : add4 ? `ASCN_ADD_LAST4 : `ASCN_ADD_LAST2;
  wire        last_pass  = (add_cnt_reg == add_last);
  wire        store_en   = conv_ok & last_pass;
  wire        resume     = grp_mode & (grp_reg == GRP_A) & susp_valid_reg & rscn;
  wire        dbl_grp    = dbl_on & (grp_reg == GRP_A) & ~xdup_scan_reg;
  // reduced resolution drops low bits before summing
  wire [2:0]  res_sh     = res == 2'h1 ? 3'h2 : res == 2'h2 ? 3'h4 : 3'h0;
  wire [11:0] res_val    = conv_rsp.data >> res_sh;
  wire [15:0] sum        = acc_reg + {4'h0, res_val};
  wire [4:0]  store_idx  = xdup_scan_reg                  ? `ASCN_SLOT_XDUP :
                           (dbl_grp && dbl_second_reg)    ? `ASCN_SLOT_DUP : ch_reg;
  wire [2:0]  div_last   = 3'((4'h1 << ratio) - 4'h1);
  wire [2:0]  div_next   = (div_cnt_reg == 3'h0) ? div_last : div_cnt_reg - 3'h1;

  // ----------------------------------------------------------------
  // apb answer: one wait-free access after setup
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~map_hit;
      prdata_reg  <= (setup & ~pwrite & map_hit) ? rd_word : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= `ASCN_CTRL_RST;
      trig_reg  <= `ASCN_TRIG_RST;
      sel_a_reg <= `ASCN_SEL_RST;
      sel_b_reg <= `ASCN_SEL_RST;
      sel_c_reg <= `ASCN_SEL_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= pwdata[15:0];
      if (wr_en && paddr == `ASCN_OFF_TRIG) trig_reg <= pwdata[13:0];
      if (wr_en && paddr == `ASCN_OFF_SELA) sel_a_reg <= pwdata[26:0];
      if (wr_en && paddr == `ASCN_OFF_SELB) sel_b_reg <= pwdata[26:0];
      if (wr_en && paddr == `ASCN_OFF_SELC) sel_c_reg <= pwdata[26:0];
    end
  end

  // ----------------------------------------------------------------
  // result slots: per input, temp, ref, diag, dup, extended dup
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `ASCN_NSLOT; i++) mem[i] <= 16'h0000;
    end else if (store_en) begin
      mem[store_idx] <= sum;
    end
  end

  // ----------------------------------------------------------------
  // conversion clock strobe, pin edge history
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg  <= 3'h0;
      tick_reg     <= 1'b0;
      ext_prev_reg <= 1'b1;
    end else begin
      div_cnt_reg  <= div_next;
      tick_reg     <= (div_next == 3'h0);
      ext_prev_reg <= external_start_trigger_n;
    end
  end

  // ----------------------------------------------------------------
  // scan state machine
  // ----------------------------------------------------------------
  // a new channel is only picked on a conversion clock strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      grp_reg   <= GRP_A;
      ch_reg    <= 5'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_SEEK;
            grp_reg   <= start_grp;
            ch_reg    <= 5'h00;
          end
        end
        ST_SEEK, ST_WAIT: begin
          if (stop) begin
            state_reg <= ST_IDLE;
          end else if (prio_hit) begin
            grp_reg   <= GRP_A;
            ch_reg    <= 5'h00;
            state_reg <= ST_SEEK;
          end else if (issue) begin
            ch_reg    <= pick_idx;
            state_reg <= ST_WAIT;
          end else if (scan_done && resume) begin
            grp_reg   <= susp_grp_reg;
            ch_reg    <= rsfrom ? susp_ch_reg : 5'h00;
          end else if (scan_done && mode == MODE_CONT) begin
            ch_reg    <= 5'h00;
          end else if (scan_done) begin
            state_reg <= ST_IDLE;
          end else if (conv_ok && last_pass) begin
            ch_reg    <= ch_reg + 5'h01;
            state_reg <= ST_SEEK;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // addition accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg     <= 16'h0000;
      add_cnt_reg <= 4'h0;
    end else if (issue || !busy_ok) begin
      acc_reg     <= 16'h0000;
      add_cnt_reg <= 4'h0;
    end else if (conv_ok) begin
      acc_reg     <= last_pass ? 16'h0000 : sum;
      add_cnt_reg <= last_pass ? 4'h0 : add_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // double trigger phase, extended scan, suspended scan
  // ----------------------------------------------------------------
  // the suspend point is the channel that had not finished
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbl_second_reg <= 1'b0;
      xdup_scan_reg  <= 1'b0;
      susp_valid_reg <= 1'b0;
      susp_grp_reg   <= GRP_B;
      susp_ch_reg    <= 5'h00;
    end else begin
      if (stop || !dbl_on) dbl_second_reg <= 1'b0;
      else if (scan_done && dbl_grp) dbl_second_reg <= ~dbl_second_reg;
      if (start) xdup_scan_reg <= xdup_start;
      else if (scan_done || stop) xdup_scan_reg <= 1'b0;
      if (stop) begin
        susp_valid_reg <= 1'b0;
      end else if (prio_hit) begin
        susp_valid_reg <= rscn;
        susp_grp_reg   <= grp_reg;
        susp_ch_reg    <= ch_reg;
      end else if (scan_done && grp_reg == GRP_A) begin
        susp_valid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // converter requests and scan end requests
  // ----------------------------------------------------------------
  // addition mode repeats the request on the same channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_req_reg     <= '0;
      conv_abort_reg   <= 1'b0;
      scan_end_irq_reg <= 1'b0;
      gb_irq_reg       <= 1'b0;
    end else begin
      conv_req_reg.valid <= issue | (conv_ok & ~last_pass);
      conv_req_reg.chan  <= issue ? pick_idx : ch_reg;
      conv_abort_reg     <= ~idle & (stop | prio_hit);
      scan_end_irq_reg   <= scan_done & (grp_reg == GRP_A)
                            & (~dbl_grp | dbl_second_reg);
      gb_irq_reg         <= scan_done & grp_mode & (grp_reg == GRP_B);
    end
  end

  assign prdata               = prdata_reg;
  assign pready               = pready_reg;
  assign pslverr              = pslverr_reg;
  assign conv_req             = conv_req_reg;
  assign conv_abort           = conv_abort_reg;
  assign conversion_clock     = tick_reg;
  assign scan_end_irq         = scan_end_irq_reg;
  assign group_b_scan_end_irq = gb_irq_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_single_stops: assert property (scan_done && !grp_mode && mode != MODE_CONT
    |=> state_reg == ST_IDLE) else $error("single scan did not stop");
  a_cont_wraps: assert property (scan_done && mode == MODE_CONT
    |=> state_reg == ST_SEEK && ch_reg == 5'h00) else $error("continuous scan did not wrap");
  a_req_selected: assert property (conv_req_reg.valid
    |-> ($past(cur_mask) & (27'h0000001 << conv_req_reg.chan)) != 27'h0)
    else $error("request for unselected channel");
  a_prio_abort: assert property (prio_hit
    |=> grp_reg == GRP_A && conv_abort_reg && state_reg == ST_SEEK)
    else $error("priority trigger did not abort");
  a_resume_point: assert property (scan_done && resume
    |=> grp_reg == $past(susp_grp_reg)
        && ch_reg == ($past(rsfrom) ? $past(susp_ch_reg) : 5'h00))
    else $error("wrong restart point");
  a_dbl_first: assert property (scan_done && dbl_grp && !dbl_second_reg && dbl_on
    |=> !scan_end_irq_reg && dbl_second_reg) else $error("request after first double scan");
  a_dup_store: assert property (store_en && dbl_grp && dbl_second_reg
    |-> store_idx == `ASCN_SLOT_DUP) else $error("second double result misplaced");
  a_gb_end: assert property (scan_done && grp_mode && grp_reg == GRP_B
    |=> group_b_scan_end_irq && !scan_end_irq) else $error("group B end request wrong");
  a_busy_ignore: assert property (state_reg == ST_WAIT && !prio_hit && !stop
    |=> grp_reg == $past(grp_reg)) else $error("busy scan changed group");
endmodule : ascn_top

// ---- bench/ascn_core_model.sv ----
// behavioural analog core answering conversion requests after a fixed delay
`timescale 1ns/1ps
module ascn_core_model #(parameter int DLY = 3) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // requests from the sequencer
  input  wire ascn_pkg::ascn_conv_req_s conv_req,
  input  wire logic                     conv_abort,
  // answers to the sequencer
  output ascn_pkg::ascn_conv_rsp_s      conv_rsp
);
  import ascn_pkg::*;
  int         cnt; // cycles left of the conversion in flight, 0 when idle
  logic [4:0] ch;  // channel in flight
  // result carries 8 in the top nibble and the channel below it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      ch <= 5'h00;
      conv_rsp <= '0;
    end else begin
      conv_rsp.done <= (cnt == 1) && !conv_abort;
      // between answers the data line toggles between the last result and its inverse
      conv_rsp.data <= (cnt == 1) ? {7'h40, ch} : ~conv_rsp.data;
      if (conv_abort) cnt <= 0;
      else if (conv_req.valid) begin
        cnt <= DLY;
        ch <= conv_req.chan;
      end else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule : ascn_core_model

// ---- bench/tb_top.sv ----
// self-checking bench of the scan sequencer
`timescale 1ns/1ps
module tb_top;
  import ascn_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_n, elu, e;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rd;
  ascn_conv_req_s req;
  ascn_conv_rsp_s rsp;
  int             err_count, samples_checked, irqs, irqs_b;
  logic [4:0]     q[$]; // channels requested, in order
  wire            abort, cclk, irq, irq_b;
  ascn_top i_ascn_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .multifunction_timer_unit_trig(1'b0), .pulse_timer_unit_trig(1'b0),
    .eight_bit_timer_unit_trig(1'b0), .event_link_unit_trig(elu),
    .external_start_trigger_n(ext_n), .conv_req(req), .conv_abort(abort), .conv_rsp(rsp),
    .conversion_clock(cclk), .scan_end_irq(irq), .group_b_scan_end_irq(irq_b));
  ascn_core_model i_ascn_core_model (.pclk(pclk), .presetn(presetn), .conv_req(req),
    .conv_abort(abort), .conv_rsp(rsp));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // monitor of requests and end pulses, each of which stands one cycle
  always @(posedge pclk) begin
    if (req.valid === 1'b1) q.push_back(req.chan);
    if (irq === 1'b1) irqs++;
    if (irq_b === 1'b1) irqs_b++;
  end
  task chk(string n, logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high at a rising edge,
  // read data and error taken at that same edge, released only after it
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // bounded wait for end pulses, then a settle time of 20 cycles
  task wt(int n, int nb);
    for (int k = 0; k < 400 && (irqs < n || irqs_b < nb); k++) @(posedge pclk);
    repeat (20) @(posedge pclk);
  endtask : wt
  task setup(logic [31:0] ctrl, logic [31:0] sa, logic [31:0] sb, logic [31:0] tr);
    apb(1'b1, 8'h00, ctrl);
    apb(1'b1, 8'h04, sa);
    apb(1'b1, 8'h08, sb);
    apb(1'b1, 8'h10, tr);
    irqs = 0;
    irqs_b = 0;
    q.delete();
  endtask : setup
  task t_single;
    setup(32'h0, 32'h0100_0028, 32'h0, 32'h0);
    apb(1'b1, 8'h18, 32'h1);
    wt(1, 0);
    chk("irq", irqs, 1);
    chk("count", q.size(), 3);
    chk("ch0", q[0], 3);
    chk("ch1", q[1], 5);
    chk("ch2", q[2], 24);
    apb(1'b0, 8'h4c, 32'h0);
    chk("slot3", rd, 32'h803);
    apb(1'b0, 8'h14, 32'h0);
    chk("busy", rd[0], 1'b0);
    apb(1'b0, 8'h20, 32'h0);
    chk("pslverr", e, 1'b1);
    $display("test single done");
  endtask : t_single
  task t_cont;
    setup(32'h1, 32'h2, 32'h0, 32'h0);
    apb(1'b1, 8'h18, 32'h1);
    wt(2, 0);
    apb(1'b1, 8'h18, 32'h8);
    chk("again", q[1], 1);
    apb(1'b0, 8'h14, 32'h0);
    chk("stopped", rd[0], 1'b0);
    $display("test continuous done");
  endtask : t_cont
  // group b from the event link, group a from the pin
  task t_group;
    setup(32'h2, 32'h4, 32'h80, 32'h25);
    @(posedge pclk) elu <= 1'b1;
    @(posedge pclk) elu <= 1'b0;
    wt(0, 1);
    chk("b only", {irqs, q[0]}, {32'd0, 5'd7});
    chk("b end", irqs_b, 1);
    @(posedge pclk) ext_n <= 1'b0;
    @(posedge pclk) ext_n <= 1'b1;
    wt(1, 1);
    chk("a pin", {irqs, q[1]}, {32'd1, 5'd2});
    $display("test group done");
  endtask : t_group
  // group b cut by a priority group a start, then rescanned from the unfinished channel
  task t_prio;
    setup(32'h3a, 32'h4, 32'h380, 32'h0);
    apb(1'b1, 8'h18, 32'h2);
    apb(1'b1, 8'h18, 32'h1);
    wt(1, 1);
    chk("b cut", q[0], 7);
    chk("a first", q[1], 2);
    chk("resume", q[2], 7);
    chk("rescan", q.size(), 5);
    chk("a end", irqs, 1);
    chk("b end", irqs_b, 1);
    $display("test priority done");
  endtask : t_prio
  // two starts of a double scan on channel 4; only the second ends the scan
  task t_dbl;
    setup(32'h4, 32'h1, 32'h0, 32'h800);
    apb(1'b1, 8'h18, 32'h1);
    repeat (30) @(posedge pclk);
    chk("no irq", irqs, 0);
    apb(1'b1, 8'h18, 32'h1);
    wt(1, 0);
    chk("irq", irqs, 1);
    chk("count", q.size(), 2);
    chk("chan", q[1], 4);
    apb(1'b0, 8'h50, 32'h0);
    chk("first", rd, 32'h804);
    apb(1'b0, 8'hac, 32'h0);
    chk("dup", rd, 32'h804);
    $display("test double done");
  endtask : t_dbl
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    {presetn, psel, penable, pwrite, elu, paddr, pwdata} = '0;
    ext_n = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_single();
    t_cont();
    t_group();
    t_prio();
    t_dbl();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    tally_and_finish();
  end
endmodule : tb_top
